// File: hw/sli_regs.vh
`ifndef SLI_REGS_VH
`define SLI_REGS_VH

// ==========================================
// Time base
`define SLI_CLK_HZ 10000000
`define SLI_TICK_MS 1
`define SLI_CYC_PER_MS ((`SLI_CLK_HZ / 1000) * `SLI_TICK_MS)

// ==========================================
// Pattern phase times in ms
`define SLI_BLINK_ON_MS 200
`define SLI_BLINK_OFF_MS 200
`define SLI_FLICK_ON_MS 50
`define SLI_FLICK_OFF_MS 50
`define SLI_FLASH_ON_MS 200
`define SLI_FLASH_GAP_MS 1000
`define SLI_DBL_PERIOD_MS 1600
`define SLI_SGL_PERIOD_MS 1200

// ==========================================
// Run state encodings
`define SLI_RUN_INIT 3'h0
`define SLI_RUN_BOOT 3'h1
`define SLI_RUN_PREOP 3'h2
`define SLI_RUN_SAFEOP 3'h3
`define SLI_RUN_OP 3'h4

// ==========================================
// Error encodings
`define SLI_ERR_NONE 3'h0
`define SLI_ERR_CHG_FAIL 3'h1
`define SLI_ERR_CFG 3'h2
`define SLI_ERR_WDOG 3'h3
`define SLI_ERR_FW_FAIL 3'h4

// ==========================================
// Boot phase encodings
`define SLI_BOOT_RUNNING 2'h0
`define SLI_BOOT_DONE 2'h1
`define SLI_BOOT_FAILED 2'h2

`endif

// File: hw/sli_sync2.v
`timescale 1ns/1ps
// ==========================================
// Two-stage synchroniser for pin-level inputs
module sli_sync2 #(
	parameter W = 1
) (
	input wire i_sys_clk,
	input wire i_nrst,
	input wire [W-1:0] i_async,
	output wire [W-1:0] o_sync
);
	reg [W-1:0] meta_q;
	reg [W-1:0] sync_q;

	always @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			meta_q <= {W{1'b0}};
			sync_q <= {W{1'b0}};
		end else begin
			meta_q <= i_async;
			sync_q <= meta_q;
		end
	end

	assign o_sync = sync_q;
endmodule

// File: hw/sli_status_led.v
`timescale 1ns/1ps
`include "sli_regs.vh"

// Overview of operation
// - Blinking: 200 ms on, 200 ms off, repeating.
// - Flickering: 50 ms on, 50 ms off, repeating.
// - Single flash: 200 ms on, 1000 ms off, repeating.
// - Double flash: on 200, off 200, on 200, off 1000 ms, repeating.
// - Health lamp steady when powered, flickers when update done needs restart.
// - Flash-write lamp lit while nonvolatile write in progress.
// - Primary run lamp: off, flicker, blink, single flash, on by state.
// - Error lamp: off none, blink change failed, single flash config error.
// - Error lamp double-flashes on buffer manager watchdog expiry.
// - Primary error lamp flickers on failed firmware update; secondary never.
// - Any active error indication forces that port's run lamp off.
// - Secondary uses same encodings, without bootstrap or update-failure display.
// - Socket activity lamp off without link, blinks with link and receive.
// - Socket speed lamp lit with 100 Mbit/s link, off without link.
// - All lamps steady during boot, all flicker if boot fails.
module sli_status_led #(
	parameter CYC_PER_MS = `SLI_CYC_PER_MS
) (
	input wire i_sys_clk,
	input wire i_nrst,
	input wire [1:0] i_boot_phase,
	input wire i_fw_update_done,
	input wire i_nvm_write_busy,
	input wire [2:0] i_pri_run_state,
	input wire [2:0] i_pri_err_state,
	input wire [2:0] i_sec_run_state,
	input wire [2:0] i_sec_err_state,
	input wire [3:0] i_sock_link,
	input wire [3:0] i_sock_rx_act,
	input wire [3:0] i_sock_speed100,
	output wire o_health_lamp,
	output wire o_nvm_write_lamp,
	output wire o_pri_run_lamp,
	output wire o_pri_err_lamp,
	output wire o_sec_run_lamp,
	output wire o_sec_err_lamp,
	output wire [3:0] o_sock_act_lamp,
	output wire [3:0] o_sock_speed_lamp
);
	// Compare-only constants, kept unsized so no bits are cut
	localparam CYC_MS_M1 = CYC_PER_MS - 1;
	localparam DBL_LAST = `SLI_DBL_PERIOD_MS - 1;
	localparam SGL_LAST = `SLI_SGL_PERIOD_MS - 1;
	localparam BLINK_LAST = `SLI_BLINK_ON_MS + `SLI_BLINK_OFF_MS - 1;
	localparam FLICK_LAST = `SLI_FLICK_ON_MS + `SLI_FLICK_OFF_MS - 1;
	localparam FL_ON = `SLI_FLASH_ON_MS;
	localparam FL_ON2_START = 2 * `SLI_FLASH_ON_MS;
	localparam FL_ON2_END = 3 * `SLI_FLASH_ON_MS;
	localparam BL_ON = `SLI_BLINK_ON_MS;
	localparam FK_ON = `SLI_FLICK_ON_MS;

	// ==========================================
	// Input synchronisers
	// Status arrives from other logic and LED pads; cheap to resync all of it
	wire [1:0] boot_s;
	wire fwdone_s;
	wire nvm_s;
	wire [2:0] prun_s;
	wire [2:0] perr_s;
	wire [2:0] srun_s;
	wire [2:0] serr_s;
	wire [3:0] link_s;
	wire [3:0] rx_s;
	wire [3:0] spd_s;

	sli_sync2 #(.W(2)) u_sync_boot (
		.i_sys_clk(i_sys_clk),
		.i_nrst(i_nrst),
		.i_async(i_boot_phase),
		.o_sync(boot_s)
	);
	sli_sync2 #(.W(1)) u_sync_fwdone (
		.i_sys_clk(i_sys_clk),
		.i_nrst(i_nrst),
		.i_async(i_fw_update_done),
		.o_sync(fwdone_s)
	);
	sli_sync2 #(.W(1)) u_sync_nvm (
		.i_sys_clk(i_sys_clk),
		.i_nrst(i_nrst),
		.i_async(i_nvm_write_busy),
		.o_sync(nvm_s)
	);
	sli_sync2 #(.W(3)) u_sync_prun (
		.i_sys_clk(i_sys_clk),
		.i_nrst(i_nrst),
		.i_async(i_pri_run_state),
		.o_sync(prun_s)
	);
	sli_sync2 #(.W(3)) u_sync_perr (
		.i_sys_clk(i_sys_clk),
		.i_nrst(i_nrst),
		.i_async(i_pri_err_state),
		.o_sync(perr_s)
	);
	sli_sync2 #(.W(3)) u_sync_srun (
		.i_sys_clk(i_sys_clk),
		.i_nrst(i_nrst),
		.i_async(i_sec_run_state),
		.o_sync(srun_s)
	);
	sli_sync2 #(.W(3)) u_sync_serr (
		.i_sys_clk(i_sys_clk),
		.i_nrst(i_nrst),
		.i_async(i_sec_err_state),
		.o_sync(serr_s)
	);
	sli_sync2 #(.W(4)) u_sync_link (
		.i_sys_clk(i_sys_clk),
		.i_nrst(i_nrst),
		.i_async(i_sock_link),
		.o_sync(link_s)
	);
	sli_sync2 #(.W(4)) u_sync_rx (
		.i_sys_clk(i_sys_clk),
		.i_nrst(i_nrst),
		.i_async(i_sock_rx_act),
		.o_sync(rx_s)
	);
	sli_sync2 #(.W(4)) u_sync_spd (
		.i_sys_clk(i_sys_clk),
		.i_nrst(i_nrst),
		.i_async(i_sock_speed100),
		.o_sync(spd_s)
	);

	// ==========================================
	// Millisecond tick
	reg [13:0] pre_q;
	wire ms_tick = (pre_q == CYC_MS_M1);

	always @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			pre_q <= 14'h0000;
		end else if (ms_tick) begin
			pre_q <= 14'h0000;
		end else begin
			pre_q <= pre_q + 14'h0001;
		end
	end

	// ==========================================
	// Pattern phase counters, all advanced by the one tick
	// Separate counters keep each period exact; one shared counter cannot divide all
	reg [6:0] flk_q;
	reg [8:0] blk_q;
	reg [10:0] sgl_q;
	reg [10:0] dbl_q;

	always @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			flk_q <= 7'h00;
		end else if (ms_tick) begin
			flk_q <= (flk_q == FLICK_LAST) ? 7'h00 : flk_q + 7'h01;
		end
	end

	always @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			blk_q <= 9'h000;
		end else if (ms_tick) begin
			blk_q <= (blk_q == BLINK_LAST) ? 9'h000 : blk_q + 9'h001;
		end
	end

	always @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			sgl_q <= 11'h000;
		end else if (ms_tick) begin
			sgl_q <= (sgl_q == SGL_LAST) ? 11'h000 : sgl_q + 11'h001;
		end
	end

	always @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			dbl_q <= 11'h000;
		end else if (ms_tick) begin
			dbl_q <= (dbl_q == DBL_LAST) ? 11'h000 : dbl_q + 11'h001;
		end
	end

	wire pat_flick = (flk_q < FK_ON);
	wire pat_blink = (blk_q < BL_ON);
	wire pat_single = (sgl_q < FL_ON);
	wire pat_double = (dbl_q < FL_ON) ||
		((dbl_q >= FL_ON2_START) && (dbl_q < FL_ON2_END));

	// ==========================================
	// Per-lamp pattern selection
	function run_pat;
		input [2:0] st;
		input has_boot;
		input fl;
		input bl;
		input sg;
		begin
			case (st)
				`SLI_RUN_INIT: run_pat = 1'b0;
				`SLI_RUN_BOOT: run_pat = has_boot & fl;
				`SLI_RUN_PREOP: run_pat = bl;
				`SLI_RUN_SAFEOP: run_pat = sg;
				`SLI_RUN_OP: run_pat = 1'b1;
				default: run_pat = 1'b0;
			endcase
		end
	endfunction

	function err_pat;
		input [2:0] st;
		input has_fw;
		input fl;
		input bl;
		input sg;
		input db;
		begin
			case (st)
				`SLI_ERR_NONE: err_pat = 1'b0;
				`SLI_ERR_CHG_FAIL: err_pat = bl;
				`SLI_ERR_CFG: err_pat = sg;
				`SLI_ERR_WDOG: err_pat = db;
				`SLI_ERR_FW_FAIL: err_pat = has_fw & fl;
				default: err_pat = 1'b0;
			endcase
		end
	endfunction

	// Error active only for encodings the port can show
	wire pri_err_on = (perr_s != `SLI_ERR_NONE) && (perr_s <= `SLI_ERR_FW_FAIL);
	wire sec_err_on = (serr_s != `SLI_ERR_NONE) && (serr_s <= `SLI_ERR_WDOG);

	reg pri_run_n;
	reg sec_run_n;
	reg pri_err_n;
	reg sec_err_n;
	reg health_n;
	wire [3:0] act_n;
	wire [3:0] spd_n;

	always @* begin
		if (pri_err_on) begin
			pri_run_n = 1'b0;
		end else begin
			pri_run_n = run_pat(prun_s, 1'b1, pat_flick, pat_blink, pat_single);
		end
	end

	always @* begin
		if (sec_err_on) begin
			sec_run_n = 1'b0;
		end else begin
			sec_run_n = run_pat(srun_s, 1'b0, pat_flick, pat_blink, pat_single);
		end
	end

	always @* begin
		pri_err_n = err_pat(perr_s, 1'b1, pat_flick, pat_blink, pat_single, pat_double);
	end

	always @* begin
		sec_err_n = err_pat(serr_s, 1'b0, pat_flick, pat_blink, pat_single, pat_double);
	end

	always @* begin
		if (fwdone_s) begin
			health_n = pat_flick;
		end else begin
			health_n = 1'b1;
		end
	end

	genvar s;
	generate
		for (s = 0; s < 4; s = s + 1) begin : g_sock
			assign act_n[s] = link_s[s] & rx_s[s] & pat_blink;
			assign spd_n[s] = link_s[s] & spd_s[s];
		end
	endgenerate

	// ==========================================
	// Boot override and output registers
	reg [13:0] lamp_d;
	reg [13:0] lamp_q;

	always @* begin
		case (boot_s)
			`SLI_BOOT_RUNNING: lamp_d = {14{1'b1}};
			`SLI_BOOT_FAILED: lamp_d = {14{pat_flick}};
			default: lamp_d = {health_n, nvm_s, pri_run_n, pri_err_n, sec_run_n, sec_err_n,
				act_n, spd_n};
		endcase
	end

	always @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			lamp_q <= 14'h0000;
		end else begin
			lamp_q <= lamp_d;
		end
	end

	assign o_health_lamp = lamp_q[13];
	assign o_nvm_write_lamp = lamp_q[12];
	assign o_pri_run_lamp = lamp_q[11];
	assign o_pri_err_lamp = lamp_q[10];
	assign o_sec_run_lamp = lamp_q[9];
	assign o_sec_err_lamp = lamp_q[8];
	assign o_sock_act_lamp = lamp_q[7:4];
	assign o_sock_speed_lamp = lamp_q[3:0];
endmodule

// File: verification/sli_lamp_watch.sv
`timescale 1ns/1ps
// ==========================================
// Operator's eye: counts lamp turn-ons
module sli_lamp_watch (
	input wire i_sys_clk,
	input wire i_lamp,
	output reg [7:0] o_rises
);
	reg last_q = 1'b0;
	initial o_rises = 8'h00;
	always @(posedge i_sys_clk) begin
		if (i_lamp && !last_q) o_rises <= o_rises + 8'h01;
		last_q <= i_lamp;
	end
endmodule

// File: verification/sli_status_led_properties.sv
`timescale 1ns/1ps
module sli_status_led_chk (
	input wire i_sys_clk,
	input wire i_nrst,
	input wire [1:0] i_boot_phase,
	input wire i_fw_update_done,
	input wire i_nvm_write_busy,
	input wire [2:0] i_pri_run_state,
	input wire [2:0] i_pri_err_state,
	input wire [2:0] i_sec_err_state,
	input wire [3:0] i_sock_link,
	input wire [3:0] i_sock_speed100,
	input wire o_health_lamp,
	input wire o_nvm_write_lamp,
	input wire o_pri_run_lamp,
	input wire o_sec_err_lamp,
	input wire [3:0] o_sock_act_lamp,
	input wire [3:0] o_sock_speed_lamp
);
	// Inputs reach lamps after three edges, so wait four edges after reset
	reg [2:0] age_q;
	wire ok = age_q[2];
	always @(posedge i_sys_clk) begin
		if (!i_nrst) age_q <= 3'h0;
		else if (!ok) age_q <= age_q + 3'h1;
	end
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_nrst);
	sequence s_norm; ok && $past(i_boot_phase, 3) == 2'h1; endsequence
	sequence s_rel; $rose(i_nrst); endsequence
	a_nvm_lamp_follow: assert property (s_norm |-> o_nvm_write_lamp == $past(i_nvm_write_busy, 3))
		else $error("nvm lamp wrong");
	a_speed_lamp_follow: assert property (s_norm |->
		o_sock_speed_lamp == ($past(i_sock_link, 3) & $past(i_sock_speed100, 3)))
		else $error("speed lamp wrong");
	a_act_needs_link: assert property (s_norm |-> (o_sock_act_lamp & ~$past(i_sock_link, 3)) == 4'h0)
		else $error("activity without link");
	a_health_steady_on: assert property (s_norm ##0 !$past(i_fw_update_done, 3) |-> o_health_lamp)
		else $error("health lamp dark");
	a_run_err_mask: assert property (s_norm ##0 $past(i_pri_err_state, 3) inside {[3'h1:3'h4]}
		|-> !o_pri_run_lamp)
		else $error("run lamp not masked");
	a_run_init_dark: assert property (s_norm ##0 $past(i_pri_run_state, 3) == 3'h0 |-> !o_pri_run_lamp)
		else $error("run lamp lit in init");
	a_sec_fw_dark: assert property (s_norm ##0 $past(i_sec_err_state, 3) == 3'h4 |-> !o_sec_err_lamp)
		else $error("secondary error lamp lit");
	a_boot_all_lit: assert property (ok && $past(i_boot_phase, 3) == 2'h0 |-> o_health_lamp &&
		o_nvm_write_lamp && o_pri_run_lamp && o_sec_err_lamp && (&o_sock_act_lamp))
		else $error("boot lamps not lit");
	a_reset_on_phase: assert property (s_rel |-> ##[1:3] o_health_lamp)
		else $error("no on phase after reset");
endmodule
bind sli_status_led sli_status_led_chk u_chk (.i_sys_clk, .i_nrst, .i_boot_phase,
	.i_fw_update_done, .i_nvm_write_busy, .i_pri_run_state, .i_pri_err_state, .i_sec_err_state,
	.i_sock_link, .i_sock_speed100, .o_health_lamp, .o_nvm_write_lamp, .o_pri_run_lamp,
	.o_sec_err_lamp, .o_sock_act_lamp, .o_sock_speed_lamp);

// File: verification/sli_status_led_test.sv
`timescale 1ns/1ps
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin err_count++; \
	$display("[FAIL] %s exp %h got %h", n, e, a); end end
module sli_status_led_test;
	reg clk = 1'b0;
	reg nrst = 1'b0;
	reg [1:0] boot = 2'h1;
	reg fw = 1'b1;
	reg nvm = 1'b1;
	reg [2:0] prun = 3'h1, perr = 3'h0, srun = 3'h2, serr = 3'h3;
	reg [3:0] link = 4'h7, rx = 4'h3, spd = 4'h5;
	wire hl, nl, pr, pe, sr, se;
	wire [3:0] al, sl;
	wire [7:0] rises;
	integer err_count = 0;
	integer cmp_count = 0;
	initial forever #50 clk = ~clk;
	// Ten clocks stand for one millisecond to keep the run short
	sli_status_led #(.CYC_PER_MS(10)) u_sli_status_led (.i_sys_clk(clk), .i_nrst(nrst),
		.i_boot_phase(boot),
		.i_fw_update_done(fw), .i_nvm_write_busy(nvm), .i_pri_run_state(prun),
		.i_pri_err_state(perr), .i_sec_run_state(srun), .i_sec_err_state(serr),
		.i_sock_link(link), .i_sock_rx_act(rx), .i_sock_speed100(spd), .o_health_lamp(hl),
		.o_nvm_write_lamp(nl), .o_pri_run_lamp(pr), .o_pri_err_lamp(pe), .o_sec_run_lamp(sr),
		.o_sec_err_lamp(se), .o_sock_act_lamp(al), .o_sock_speed_lamp(sl));
	sli_lamp_watch u_sli_lamp_watch (.i_sys_clk(clk), .i_lamp(hl), .o_rises(rises));
	task wait_ms(input integer n);
		repeat (n * 10) @(posedge clk);
		#10;
	endtask
	task summarize;
		$display("compares %0d errors %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// ==========================================
	// Checks sit mid-phase, clear of the few-cycle input lag
	initial begin
		repeat (10) @(posedge clk);
		#10 nrst = 1'b1;
		wait_ms(25);
		`CHK("lamps", 6'b111001, {hl, nl, pr, pe, sr, se})
		`CHK("sock", 8'h35, {al, sl})
		wait_ms(50);
		`CHK("lamps", 6'b010001, {hl, nl, pr, pe, sr, se})
		`CHK("sock", 8'h35, {al, sl})
		nvm = 1'b0;
		fw = 1'b0;
		prun = 3'h0;
		perr = 3'h4;
		srun = 3'h4;
		serr = 3'h4;
		rx = 4'hf;
		wait_ms(10);
		`CHK("lamps", 6'b100010, {hl, nl, pr, pe, sr, se})
		`CHK("sock", 8'h75, {al, sl})
		wait_ms(20);
		`CHK("lamps", 6'b100110, {hl, nl, pr, pe, sr, se})
		`CHK("rises", 8'h02, rises)
		perr = 3'h2;
		serr = 3'h1;
		wait_ms(10);
		`CHK("lamps", 6'b100101, {hl, nl, pr, pe, sr, se})
		wait_ms(200);
		`CHK("lamps", 6'b100000, {hl, nl, pr, pe, sr, se})
		`CHK("sock", 8'h05, {al, sl})
		boot = 2'h2;
		wait_ms(10);
		`CHK("fail on", 14'h3fff, {hl, nl, pr, pe, sr, se, al, sl})
		wait_ms(50);
		`CHK("fail off", 14'h0000, {hl, nl, pr, pe, sr, se, al, sl})
		boot = 2'h0;
		wait_ms(1);
		`CHK("lamps", 6'h3f, {hl, nl, pr, pe, sr, se})
		`CHK("sock", 8'hff, {al, sl})
		summarize;
	end
	initial begin
		#500000;
		err_count++;
		summarize;
	end
endmodule
